//--- shared/irq_map_pkg.sv
// Constants, register map and carriers of the interrupt source map
// Contract
// - Supply monitor sets group one bit 6 on both crossings, never wakes.
// - Die warning sets group one bit 5 on both edges, only when on.
// - Power-off pin edge of either polarity sets group one bit 4, never wakes.
// - Button held low past programmed delay sets group one bit 2, never wakes.
// - Button fall while on sets group one bit 1, always wakes.
// - Rising short indication sets group two bit 6, wakes only unmasked.
// - First-supply rise sets group two bit 5 when selected, wakes unmasked.
// - Reset pin rise sets group two bit 4, never wakes.
// - Watchdog expiry rise sets group two bit 2, never wakes.
// - Memory integrity error rise sets group two bit 1, never wakes.
// - Bus supply comparator both edges set group three bit 7, wakes unmasked.
// - Software measurement done sets group three bit 2, wakes unmasked.
// - Auto channel alarms set group three bits 1 and 0, wake unmasked.
// - General pins 0-6 set group four bits on configured edges.
// - Factory strap picks two I2C ports or one SPI port.
// - The fitted control port reaches every register.
// - First I2C port configures, second only changes converter voltages.
// - Voltage-scaling port reaches only the voltage scaling registers.
// - Set unmasked status bits OR onto one pin, low-active by default.
// - Masking stops new sets; an already set bit stays until cleared.
// - Clear on read clears a group, or write one clears written bits.
// - Pending option holds one repeat event needing a second clear.
package irq_map_pkg;

   // Register offsets
   localparam logic [7:0] STATUS_BASE = 8'h00;
   localparam logic [7:0] MASK_BASE = 8'h04;
   localparam logic [7:0] LINE_BASE = 8'h08;
   localparam logic [7:0] EDGE_RISE_ADDR = 8'h0c;
   localparam logic [7:0] EDGE_FALL_ADDR = 8'h0d;
   localparam logic [7:0] CTRL_ADDR = 8'h0e;
   localparam logic [7:0] HOLD_DELAY_ADDR = 8'h0f;
   localparam logic [7:0] VSCALE_BASE = 8'h10;
   localparam int VSCALE_COUNT = 4;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;

   // Control register fields and reset values
   localparam int CTRL_POLARITY = 0;
   localparam int CTRL_CLEAR_ON_WRITE = 1;
   localparam int CTRL_PENDING = 2;
   localparam int CTRL_FIRST_SUPPLY_SELECT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] EDGE_RISE_RESET = 8'h7f;
   localparam logic [7:0] EDGE_FALL_RESET = 8'h00;
   localparam logic [7:0] HOLD_DELAY_RESET = 8'h06;
   localparam logic [7:0] VSCALE_RESET = 8'h00;

   // Bit positions inside the 32-bit status vector (group n at 8*(n-1))
   localparam int B_SUPPLY_MON = 6;
   localparam int B_DIE_WARN = 5;
   localparam int B_POWER_OFF = 4;
   localparam int B_LONG_PRESS = 2;
   localparam int B_BUTTON = 1;
   localparam int B_SHORT = 14;
   localparam int B_FIRST_SUPPLY = 13;
   localparam int B_RESET_PIN = 12;
   localparam int B_WATCHDOG = 10;
   localparam int B_OTP_ERROR = 9;
   localparam int B_BUS_SUPPLY = 23;
   localparam int B_MEASURE_DONE = 18;
   localparam int B_AUTO_CH1 = 17;
   localparam int B_AUTO_CH0 = 16;
   localparam int B_GPIO = 24;
   localparam int GPIO_COUNT = 7;

   // Listed bits per group, and bits able to wake while unmasked
   localparam logic [31:0] LISTED_BITS = 32'h7f87_7676;
   localparam logic [31:0] WAKE_CAPABLE = 32'h7f87_6000;

   // Long-press time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

   // Pin index in the synchroniser vector
   localparam int P_POWER_OFF = 0;
   localparam int P_BUTTON = 1;
   localparam int P_RESET = 2;
   localparam int P_BUS = 3;
   localparam int P_GPIO = 4;
   localparam int PIN_COUNT = 11;

   typedef struct packed {
      logic valid;
      logic write;
      logic vs_port;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } reg_rsp_type;

   typedef struct packed {
      logic supply_voltage_monitor;
      logic die_overtemp_warning;
      logic short_any;
      logic first_supply_detect;
      logic watchdog_expiry;
      logic otp_error;
      logic measure_done_sw;
      logic auto_measure_ch1_alarm;
      logic auto_measure_ch0_alarm;
   } internal_event_type;

   typedef struct packed {
      logic power_off_request_pin;
      logic power_button_pin;
      logic reset_in_pin;
      logic bus_supply_present;
      logic [6:0] gpio_pin;
   } pin_event_type;

endpackage

//--- design/pmic_interrupt_source_map.sv
// Interrupt source aggregation, status groups and register access
`timescale 1ns/1ps
module pmic_interrupt_source_map #(
   parameter int TICK_CYCLES = irq_map_pkg::TICK_CYCLES,
   parameter int VSCALE_COUNT = irq_map_pkg::VSCALE_COUNT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_selected,
   input wire logic device_on,
   input wire irq_map_pkg::internal_event_type int_events,
   input wire irq_map_pkg::pin_event_type pin_events,
   input wire irq_map_pkg::reg_req_type reg_req,
   output irq_map_pkg::reg_rsp_type reg_rsp,
   output logic irq_pin_q,
   output logic wake_request_q,
   output logic [VSCALE_COUNT*8-1:0] vscale_q
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [irq_map_pkg::PIN_COUNT-1:0] pin_raw;
   logic [irq_map_pkg::PIN_COUNT-1:0] sync1_q;
   logic [irq_map_pkg::PIN_COUNT-1:0] sync2_q;
   logic [irq_map_pkg::PIN_COUNT-1:0] pin_prev_q;
   logic [irq_map_pkg::PIN_COUNT-1:0] pin_rise;
   logic [irq_map_pkg::PIN_COUNT-1:0] pin_fall;
   logic [8:0] int_now;
   logic [8:0] int_prev_q;
   logic [8:0] int_rise;
   logic [8:0] int_fall;
   logic [31:0] event_d;
   logic [31:0] status_q;
   logic [31:0] pending_q;
   logic [31:0] mask_q;
   logic [31:0] clear_bits;
   logic [31:0] line_state;
   logic [7:0] edge_rise_q;
   logic [7:0] edge_fall_q;
   logic [7:0] ctrl_q;
   logic [7:0] hold_delay_q;
   logic [31:0] tick_cnt_q;
   logic tick;
   logic [7:0] hold_cnt_q;
   logic long_press_fired_q;
   logic long_press_evt;
   logic [2:0] last_clear_q;
   logic req_ok;
   logic in_status;
   logic in_mask;
   logic in_line;
   logic in_vscale;
   logic [1:0] grp;
   logic [7:0] vs_off;
   logic [7:0] rdata_d;
   logic button_wake;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   assign pin_raw = {pin_events.gpio_pin, pin_events.bus_supply_present,
                     pin_events.reset_in_pin, pin_events.power_button_pin,
                     pin_events.power_off_request_pin};

   // Two flops before any edge logic; the first is read by the second only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         pin_prev_q <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         pin_prev_q <= sync2_q;
      end
   end

   assign pin_rise = sync2_q & ~pin_prev_q;
   assign pin_fall = ~sync2_q & pin_prev_q;

   // Internal events are already in this clock domain
   assign int_now = {int_events.supply_voltage_monitor,
                     int_events.die_overtemp_warning, int_events.short_any,
                     int_events.first_supply_detect,
                     int_events.watchdog_expiry, int_events.otp_error,
                     int_events.measure_done_sw,
                     int_events.auto_measure_ch1_alarm,
                     int_events.auto_measure_ch0_alarm};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         int_prev_q <= '0;
      end else begin
         int_prev_q <= int_now;
      end
   end

   assign int_rise = int_now & ~int_prev_q;
   assign int_fall = ~int_now & int_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Long-press timing: 1 ms tick from a divider
   always_ff @(posedge ref_clk) begin
      if (rst || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end

   assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

   // Counts whole ticks while held low; fires once per press
   always_ff @(posedge ref_clk) begin
      if (rst || sync2_q[irq_map_pkg::P_BUTTON]) begin
         hold_cnt_q <= '0;
         long_press_fired_q <= 1'b0;
      end else if (tick && !long_press_fired_q) begin
         if (hold_cnt_q >= hold_delay_q) begin
            long_press_fired_q <= 1'b1;
         end else begin
            hold_cnt_q <= hold_cnt_q + 8'h01;
         end
      end
   end

   assign long_press_evt = tick && !long_press_fired_q &&
                           !sync2_q[irq_map_pkg::P_BUTTON] &&
                           (hold_cnt_q >= hold_delay_q);

   ////////////////////////////////////////////////////////////////////////
   // Event vector, one bit per status position
   always_comb begin
      event_d = '0;
      event_d[irq_map_pkg::B_SUPPLY_MON] = int_rise[8] | int_fall[8];
      event_d[irq_map_pkg::B_DIE_WARN] = (int_rise[7] | int_fall[7]) &
                                         device_on;
      event_d[irq_map_pkg::B_POWER_OFF] =
         pin_rise[irq_map_pkg::P_POWER_OFF] |
         pin_fall[irq_map_pkg::P_POWER_OFF];
      event_d[irq_map_pkg::B_LONG_PRESS] = long_press_evt;
      event_d[irq_map_pkg::B_BUTTON] = pin_fall[irq_map_pkg::P_BUTTON] &
                                       device_on;
      event_d[irq_map_pkg::B_SHORT] = int_rise[6];
      event_d[irq_map_pkg::B_FIRST_SUPPLY] = int_rise[5] &
         ctrl_q[irq_map_pkg::CTRL_FIRST_SUPPLY_SELECT];
      event_d[irq_map_pkg::B_RESET_PIN] = pin_rise[irq_map_pkg::P_RESET];
      event_d[irq_map_pkg::B_WATCHDOG] = int_rise[4];
      event_d[irq_map_pkg::B_OTP_ERROR] = int_rise[3];
      event_d[irq_map_pkg::B_BUS_SUPPLY] = pin_rise[irq_map_pkg::P_BUS] |
                                           pin_fall[irq_map_pkg::P_BUS];
      // No edge choice: result-ready strobes taken as they come
      event_d[irq_map_pkg::B_MEASURE_DONE] = int_rise[2];
      event_d[irq_map_pkg::B_AUTO_CH1] = int_rise[1];
      event_d[irq_map_pkg::B_AUTO_CH0] = int_rise[0];
      for (int i = 0; i < irq_map_pkg::GPIO_COUNT; i++) begin
         event_d[irq_map_pkg::B_GPIO + i] =
            (pin_rise[irq_map_pkg::P_GPIO + i] & edge_rise_q[i]) |
            (pin_fall[irq_map_pkg::P_GPIO + i] & edge_fall_q[i]);
      end
   end

   // Real-time level of each source
   assign line_state = irq_map_pkg::LISTED_BITS & {
      1'b0, sync2_q[irq_map_pkg::P_GPIO +: irq_map_pkg::GPIO_COUNT],
      sync2_q[irq_map_pkg::P_BUS], 4'h0, int_now[2:0],
      1'b0, int_now[6:5], sync2_q[irq_map_pkg::P_RESET], 1'b0, int_now[4:3],
      1'b0, 1'b0, int_now[8:7], sync2_q[irq_map_pkg::P_POWER_OFF], 1'b0,
      long_press_fired_q, ~sync2_q[irq_map_pkg::P_BUTTON], 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // Request decode and port routing
   assign grp = reg_req.addr[1:0];
   assign vs_off = reg_req.addr - irq_map_pkg::VSCALE_BASE;
   assign in_status = reg_req.addr[7:2] == irq_map_pkg::STATUS_BASE[7:2];
   assign in_mask = reg_req.addr[7:2] == irq_map_pkg::MASK_BASE[7:2];
   assign in_line = reg_req.addr[7:2] == irq_map_pkg::LINE_BASE[7:2];
   assign in_vscale = (reg_req.addr >= irq_map_pkg::VSCALE_BASE) &&
                      (vs_off < 8'(VSCALE_COUNT));

   // With SPI fitted the second pins carry SPI, so no second port exists
   assign req_ok = reg_req.valid &&
                   (!reg_req.vs_port || (!spi_selected && in_vscale));

   // Status bits cleared by this access; a repeat on the same group is void
   always_comb begin
      clear_bits = '0;
      if (req_ok && in_status && (last_clear_q != {1'b0, grp})) begin
         if (reg_req.write && ctrl_q[irq_map_pkg::CTRL_CLEAR_ON_WRITE]) begin
            clear_bits[grp*8 +: 8] = reg_req.wdata;
         end else if (!reg_req.write &&
                      !ctrl_q[irq_map_pkg::CTRL_CLEAR_ON_WRITE]) begin
            clear_bits[grp*8 +: 8] = 8'hff;
         end
      end
   end

   // Remember the last group that took a clear access
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         last_clear_q <= 3'h4;
      end else if (req_ok && in_status && (clear_bits[grp*8 +: 8] != 8'h00
                   || last_clear_q == {1'b0, grp})) begin
         last_clear_q <= {1'b0, grp};
      end else if (req_ok && !in_status) begin
         last_clear_q <= 3'h4;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status and pending flags, one per source position
   for (genvar b = 0; b < 32; b++) begin : g_status
      if (irq_map_pkg::LISTED_BITS[b]) begin : g_listed
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               status_q[b] <= 1'b0;
               pending_q[b] <= 1'b0;
            end else if (event_d[b] && !mask_q[b]) begin
               // Set wins over a clear in the same cycle
               if (status_q[b] && !(clear_bits[b] && !pending_q[b])) begin
                  pending_q[b] <= ctrl_q[irq_map_pkg::CTRL_PENDING] |
                                  (pending_q[b] & !clear_bits[b]);
               end else begin
                  status_q[b] <= 1'b1;
               end
            end else if (clear_bits[b]) begin
               if (pending_q[b]) begin
                  pending_q[b] <= 1'b0;
               end else begin
                  status_q[b] <= 1'b0;
               end
            end
         end
      end else begin : g_unlisted
         assign status_q[b] = 1'b0;
         assign pending_q[b] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Writable configuration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mask_q <= {4{irq_map_pkg::MASK_RESET}};
         edge_rise_q <= irq_map_pkg::EDGE_RISE_RESET;
         edge_fall_q <= irq_map_pkg::EDGE_FALL_RESET;
         ctrl_q <= irq_map_pkg::CTRL_RESET;
         hold_delay_q <= irq_map_pkg::HOLD_DELAY_RESET;
         vscale_q <= {VSCALE_COUNT{irq_map_pkg::VSCALE_RESET}};
      end else if (req_ok && reg_req.write) begin
         if (in_mask) begin
            mask_q[grp*8 +: 8] <= reg_req.wdata &
                                  irq_map_pkg::LISTED_BITS[grp*8 +: 8];
         end
         if (reg_req.addr == irq_map_pkg::EDGE_RISE_ADDR) begin
            edge_rise_q <= {1'b0, reg_req.wdata[6:0]};
         end
         if (reg_req.addr == irq_map_pkg::EDGE_FALL_ADDR) begin
            edge_fall_q <= {1'b0, reg_req.wdata[6:0]};
         end
         if (reg_req.addr == irq_map_pkg::CTRL_ADDR) begin
            ctrl_q <= {4'h0, reg_req.wdata[3:0]};
         end
         if (reg_req.addr == irq_map_pkg::HOLD_DELAY_ADDR) begin
            hold_delay_q <= reg_req.wdata;
         end
         if (in_vscale) begin
            vscale_q[vs_off[2:0]*8 +: 8] <= reg_req.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; refused and unmapped reads return all ones
   always_comb begin
      rdata_d = irq_map_pkg::UNMAPPED_READ;
      if (req_ok) begin
         if (in_status) begin
            rdata_d = status_q[grp*8 +: 8];
         end else if (in_mask) begin
            rdata_d = mask_q[grp*8 +: 8];
         end else if (in_line) begin
            rdata_d = line_state[grp*8 +: 8];
         end else if (reg_req.addr == irq_map_pkg::EDGE_RISE_ADDR) begin
            rdata_d = edge_rise_q;
         end else if (reg_req.addr == irq_map_pkg::EDGE_FALL_ADDR) begin
            rdata_d = edge_fall_q;
         end else if (reg_req.addr == irq_map_pkg::CTRL_ADDR) begin
            rdata_d = ctrl_q;
         end else if (reg_req.addr == irq_map_pkg::HOLD_DELAY_ADDR) begin
            rdata_d = hold_delay_q;
         end else if (in_vscale) begin
            rdata_d = vscale_q[vs_off[2:0]*8 +: 8];
         end
      end
   end

   // Every request is answered one cycle later, refused ones included
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp.valid <= reg_req.valid;
         reg_rsp.rdata <= reg_req.valid ? rdata_d : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Combined interrupt pin and wake request
   assign button_wake = pin_fall[irq_map_pkg::P_BUTTON] & device_on;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_pin_q <= 1'b1;
         wake_request_q <= 1'b0;
      end else begin
         irq_pin_q <= (|(status_q & ~mask_q)) ~^
                      ctrl_q[irq_map_pkg::CTRL_POLARITY];
         // Button wakes even when its mask is set
         wake_request_q <= (|(status_q & ~mask_q &
                              irq_map_pkg::WAKE_CAPABLE)) |
                           button_wake;
      end
   end

endmodule

//--- testbench/irq_map_checker_assertions.sv
// Port checker for the interrupt source map
`timescale 1ns/1ps
module irq_map_checker #(
   parameter int TICK_CYCLES = 4,
   parameter int VSCALE_COUNT = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_selected,
   input wire logic device_on,
   input wire irq_map_pkg::internal_event_type int_events,
   input wire irq_map_pkg::pin_event_type pin_events,
   input wire irq_map_pkg::reg_req_type reg_req,
   input wire irq_map_pkg::reg_rsp_type reg_rsp,
   input wire logic irq_pin_q,
   input wire logic wake_request_q,
   input wire logic [VSCALE_COUNT*8-1:0] vscale_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   chk_rsp_follows_req: assert property (
      reg_req.valid |=> reg_rsp.valid) else $error("no answer to request");
   chk_reset_line_idle: assert property (disable iff (1'b0)
      rst |=> irq_pin_q && !wake_request_q && !reg_rsp.valid)
      else $error("outputs active after reset");
   // Button fall must wake even with its status masked
   chk_button_wake_seen: assert property (
      $fell(pin_events.power_button_pin) && device_on |-> ##[1:8]
      wake_request_q) else $error("button fall gave no wake");
   chk_unlisted_read_zero: assert property (
      reg_req.valid && !reg_req.write && !reg_req.vs_port &&
      reg_req.addr == 8'h00 |=> (reg_rsp.rdata & 8'h89) == 8'h00)
      else $error("unlisted status bit set");
   chk_unmapped_read_ff: assert property (
      reg_req.valid && !reg_req.write && !reg_req.vs_port &&
      reg_req.addr >= 8'h14 |=> reg_rsp.rdata == 8'hff)
      else $error("unmapped read not ff");
   chk_strap_vs_read: assert property (
      reg_req.valid && !reg_req.write && reg_req.vs_port && spi_selected
      |=> reg_rsp.rdata == 8'hff) else $error("second port live on strap");
   chk_strap_vs_write: assert property (
      reg_req.valid && reg_req.write && reg_req.vs_port && spi_selected
      |=> $stable(vscale_q)) else $error("write through absent port");
   chk_vs_scope_read: assert property (
      reg_req.valid && !reg_req.write && reg_req.vs_port &&
      reg_req.addr < 8'h10 |=> reg_rsp.rdata == 8'hff)
      else $error("scaling port read outside its registers");
   chk_vs_write_lands: assert property (
      reg_req.valid && reg_req.write && reg_req.vs_port && !spi_selected
      && reg_req.addr == 8'h10 |=> vscale_q[7:0] == $past(reg_req.wdata))
      else $error("scaling write lost");
   ////////////////////////////////////////////////////////////////////////
   cover property (reg_req.valid && reg_req.vs_port);
   cover property (!irq_pin_q);
   cover property (wake_request_q);
endmodule

//--- testbench/host_model.sv
// Host processor model on the register request port
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   input wire logic irq_pin_q,
   input wire irq_map_pkg::reg_rsp_type reg_rsp,
   output irq_map_pkg::reg_req_type reg_req
);
   initial begin
      reg_req = '0;
   end
   // One access; released fields show the inverse, never stale values
   task automatic access(input logic vs, wr, input logic [7:0] a, d,
                         output logic [7:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      reg_req <= {1'b1, wr, vs, a, d};
      @(posedge ref_clk);
      reg_req <= {1'b0, ~wr, ~vs, ~a, ~d};
      @(posedge ref_clk);
      while (reg_rsp.valid !== 1'b1 && n < 4) begin
         n++;
         @(posedge ref_clk);
      end
      q = (reg_rsp.valid === 1'b1) ? reg_rsp.rdata : 8'hxx;
   endtask
   // Read all groups, repeating while the line stays low, at most three passes
   task automatic clear_all;
      logic [7:0] q;
      for (int p = 0; p < 3 && irq_pin_q === 1'b0; p++) begin
         for (int g = 0; g < 4; g++) begin
            access(1'b0, 1'b0, 8'(g), 8'h00, q);
         end
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule

//--- testbench/pmic_interrupt_source_map_tb_top.sv
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps
module pmic_interrupt_source_map_tb_top;
   logic ref_clk, rst, spi_selected, device_on, irq_pin_q, wake_request_q;
   irq_map_pkg::internal_event_type int_events;
   irq_map_pkg::pin_event_type pin_events;
   irq_map_pkg::reg_req_type reg_req;
   irq_map_pkg::reg_rsp_type reg_rsp;
   logic [31:0] vscale_q;
   logic [7:0] q;
   int err_count, tests_run;

   // Short tick keeps the long-press wait small
   pmic_interrupt_source_map #(.TICK_CYCLES(4), .VSCALE_COUNT(4)) u_dut (
      .ref_clk(ref_clk), .rst(rst), .spi_selected(spi_selected),
      .device_on(device_on), .int_events(int_events),
      .pin_events(pin_events), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .irq_pin_q(irq_pin_q), .wake_request_q(wake_request_q),
      .vscale_q(vscale_q));
   host_model u_host (.ref_clk(ref_clk), .irq_pin_q(irq_pin_q),
      .reg_rsp(reg_rsp), .reg_req(reg_req));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, e);
      u_host.access(1'b0, 1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [7:0] a, d);
      u_host.access(1'b0, 1'b1, a, d, q);
   endtask
   task automatic vs(input logic w, input logic [7:0] a, d);
      u_host.access(1'b1, w, a, d, q);
   endtask
   task automatic flip(input bit pin, input int i);
      @(posedge ref_clk);
      if (pin) pin_events[i] <= ~pin_events[i];
      else int_events[i] <= ~int_events[i];
      repeat (8) @(posedge ref_clk);
   endtask
   // Two toggles; second toggle must set only for two-edge sources
   task automatic src(input bit pin, input int i, input logic [7:0] a, e,
                      input logic w, input bit both);
      for (int k = 0; k < 2; k++) begin
         flip(pin, i);
         // Mask read between status reads, else the next clear is void
         rd(a + 8'h04, 8'h00);
         if (k == 0 || both) begin
            chk(8'(wake_request_q), 8'(w));
            chk(8'(irq_pin_q), 8'h00);
            rd(a, e);
            repeat (3) @(posedge ref_clk);
            chk(8'(irq_pin_q), 8'h01);
         end else begin
            rd(a, 8'h00);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(8'(irq_pin_q), 8'h01);
      for (int g = 0; g < 4; g++) rd(8'(g), 8'h00);
      for (int g = 4; g < 8; g++) rd(8'(g), 8'h00);
      rd(8'h0c, 8'h7f);
      rd(8'h0d, 8'h00);
      rd(8'h0e, 8'h08);
      rd(8'h0f, 8'h06);
      rd(8'h10, 8'h00);
      rd(8'h20, 8'hff);
   endtask
   task automatic t_sources;
      src(1'b0, 8, 8'h00, 8'h40, 1'b0, 1'b1);
      device_on <= 1'b0;
      flip(1'b0, 7);
      rd(8'h00, 8'h00);
      device_on <= 1'b1;
      src(1'b0, 7, 8'h00, 8'h20, 1'b0, 1'b1);
      src(1'b1, 10, 8'h00, 8'h10, 1'b0, 1'b1);
      src(1'b0, 6, 8'h01, 8'h40, 1'b1, 1'b0);
      src(1'b0, 5, 8'h01, 8'h20, 1'b1, 1'b0);
      src(1'b1, 8, 8'h01, 8'h10, 1'b0, 1'b0);
      src(1'b0, 4, 8'h01, 8'h04, 1'b0, 1'b0);
      src(1'b0, 3, 8'h01, 8'h02, 1'b0, 1'b0);
      src(1'b1, 7, 8'h02, 8'h80, 1'b1, 1'b1);
      src(1'b0, 2, 8'h02, 8'h04, 1'b1, 1'b0);
      src(1'b0, 1, 8'h02, 8'h02, 1'b1, 1'b0);
      src(1'b0, 0, 8'h02, 8'h01, 1'b1, 1'b0);
      for (int g = 0; g < 7; g++) begin
         src(1'b1, g, 8'h03, 8'h01 << g, 1'b1, 1'b0);
      end
      wr(8'h0d, 8'h7f);
      src(1'b1, 5, 8'h03, 8'h20, 1'b1, 1'b1);
      wr(8'h0d, 8'h00);
   endtask
   // Masked button: wake still pulses, long press still records
   task automatic t_button;
      logic seen;
      seen = 1'b0;
      wr(8'h04, 8'h02);
      @(posedge ref_clk);
      pin_events.power_button_pin <= 1'b0;
      repeat (12) @(posedge ref_clk) seen = seen | (wake_request_q === 1'b1);
      chk(8'(seen), 8'h01);
      repeat (60) @(posedge ref_clk);
      // Live levels: die warning high, long press fired, button held
      rd(8'h08, 8'h26);
      pin_events.power_button_pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(8'(wake_request_q), 8'h00);
      rd(8'h00, 8'h04);
      wr(8'h04, 8'h00);
   endtask
   task automatic t_clear;
      wr(8'h0e, 8'h0a);
      flip(1'b0, 6);
      wr(8'h05, 8'h40);
      rd(8'h01, 8'h40);
      rd(8'h01, 8'h40);
      chk(8'(irq_pin_q), 8'h01);
      wr(8'h01, 8'h00);
      rd(8'h01, 8'h40);
      wr(8'h01, 8'h40);
      rd(8'h01, 8'h00);
      flip(1'b0, 6);
      flip(1'b0, 6);
      rd(8'h01, 8'h00);
      wr(8'h05, 8'h00);
      wr(8'h0e, 8'h0c);
      // Source starts high here: four toggles give two rising events
      flip(1'b0, 6);
      flip(1'b0, 6);
      flip(1'b0, 6);
      flip(1'b0, 6);
      rd(8'h01, 8'h40);
      rd(8'h04, 8'h00);
      rd(8'h01, 8'h40);
      rd(8'h04, 8'h00);
      rd(8'h01, 8'h00);
      flip(1'b0, 6);
      flip(1'b0, 6);
      u_host.clear_all();
      rd(8'h01, 8'h00);
      wr(8'h0e, 8'h09);
      repeat (3) @(posedge ref_clk);
      chk(8'(irq_pin_q), 8'h00);
      wr(8'h0e, 8'h08);
   endtask
   task automatic t_ports;
      vs(1'b1, 8'h10, 8'h3c);
      vs(1'b0, 8'h10, 8'h00);
      chk(q, 8'h3c);
      chk(vscale_q[7:0], 8'h3c);
      vs(1'b1, 8'h04, 8'h55);
      rd(8'h04, 8'h00);
      vs(1'b0, 8'h00, 8'h00);
      chk(q, 8'hff);
      @(posedge ref_clk);
      spi_selected <= 1'b1;
      vs(1'b1, 8'h11, 8'haa);
      vs(1'b0, 8'h11, 8'h00);
      chk(q, 8'hff);
      chk(vscale_q[15:8], 8'h00);
      wr(8'h11, 8'h5a);
      rd(8'h11, 8'h5a);
      spi_selected <= 1'b0;
   endtask
   task automatic end_sim;
      $display("errors=%0d checks=%0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      tests_run = 0;
      rst = 1'b1;
      spi_selected = 1'b0;
      device_on = 1'b1;
      int_events = '0;
      pin_events = 11'h200;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_sources();
      t_button();
      t_clear();
      t_ports();
      end_sim();
   end
   // Hang guard, well past the expected run of about a thousand cycles
   initial begin
      #300000;
      err_count++;
      end_sim();
   end
endmodule

bind pmic_interrupt_source_map irq_map_checker #(
   .TICK_CYCLES(TICK_CYCLES), .VSCALE_COUNT(VSCALE_COUNT)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .spi_selected(spi_selected),
   .device_on(device_on), .int_events(int_events),
   .pin_events(pin_events), .reg_req(reg_req), .reg_rsp(reg_rsp),
   .irq_pin_q(irq_pin_q), .wake_request_q(wake_request_q),
   .vscale_q(vscale_q));
